//--- hdl/gpio_status_top.sv
`timescale 1ns/100ps
`include "gpio_status_defs.svh"
// Behaviour
// - Function codes 0001, 0010, 0111 make a pin an input; 0111 first pin only.
// - Codes 1000, 1001, 1010 output loop 0 lock, loop 1 lock, both locked.
// - Codes 1011, 1100, 1101 output activity alarm, holdover state, interrupt.
// - First pin code 1111 puts selected input on both pins; second pin reserved.
// - Reset leaves first pin function 1011 and second pin function 1010.
// - Polarity bit resets 0; at 1 every driven pin is inverted.
// - Each alert has a mask bit, reset 0, gating it onto the interrupt.
// - Eight alerts: four input losses, two loop unlocks, holdover, reference loss.
// - Momentary input bit reads 0 on loss of signal, 1 when active.
// - Input sticky bit reads 0 after any loss since last clear.
// - Writing 1 clears an input sticky bit and its pending interrupt.
// - Momentary lock bits read 1 locked, 0 unlocked.
// - Lock sticky bits drop on unlock; write 1 clears latch and interrupt.
// - Momentary holdover bit reads 0 in holdover, 1 otherwise.
// - Holdover sticky drops on holdover; write 1 clears it and interrupt.
// - Reference sticky drops on reference loss; write 1 clears it and interrupt.
// - Momentary reference bit reads 0 without reference, 1 with one.

module gpio_status_top (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Monitor levels, asynchronous
    input  wire logic [3:0] clk_active,
    input  wire logic       loop0_locked,
    input  wire logic       loop1_locked,
    input  wire logic       in_holdover,
    input  wire logic       ref_present,
    input  wire logic [1:0] selected_input,
    // Status pins
    input  wire logic [1:0] pin_in,
    output logic      [1:0] pin_out,
    output logic      [1:0] pin_oe,
    // Pin input functions
    output logic            force_holdover,
    output logic            force_vc_half,
    output logic            ext_sel_valid,
    output logic      [1:0] ext_sel,
    // Interrupt level
    output logic            irq
);

    // ==========================================
    // Declarations
    gpio_status_pkg::func_code_t func0_r;
    gpio_status_pkg::func_code_t func1_r;
    gpio_status_pkg::alert_vec_t mask_r;
    gpio_status_pkg::alert_vec_t raw_meta_r;
    gpio_status_pkg::alert_vec_t raw_s_r;
    gpio_status_pkg::alert_vec_t good;
    gpio_status_pkg::reg_byte_t  rdata_nxt;
    logic                        pol_r;
    logic [1:0]                  sel_meta_r;
    logic [1:0]                  sel_s_r;
    logic [1:0]                  pin_meta_r;
    logic [1:0]                  pin_s_r;
    logic [1:0]                  out_nxt;
    logic [1:0]                  oe_nxt;
    logic                        alarm;
    logic [1:0]                  lvl0;
    logic [1:0]                  lvl1;
    logic                        wr_sticky;

    status_if st ();

    // ==========================================
    // Input synchronisers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            raw_meta_r <= ~`HOLD_INV;              // No-alert levels, no false drop
            raw_s_r    <= ~`HOLD_INV;              // No-alert levels, no false drop
            sel_meta_r <= '0;
            sel_s_r    <= '0;
            pin_meta_r <= '0;
            pin_s_r    <= '0;
        end else begin
            raw_meta_r <= {clk_active[0], clk_active[1], clk_active[2], clk_active[3],
                           loop0_locked, loop1_locked, in_holdover, ref_present};
            raw_s_r    <= raw_meta_r;
            sel_meta_r <= selected_input;
            sel_s_r    <= sel_meta_r;
            pin_meta_r <= pin_in;
            pin_s_r    <= pin_meta_r;
        end
    end

    // Good levels: 1 means no alert
    assign good  = raw_s_r ^ `HOLD_INV;
    assign alarm = ~(&good[`CLK_HI:`CLK_LO]);

    // ==========================================
    // Configuration registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            func0_r <= `FUNC0_RST;
            func1_r <= `FUNC1_RST;
        end else if (reg_wr && reg_addr == `ADDR_PIN_FUNC) begin
            func0_r <= reg_wdata[3:0];
            func1_r <= reg_wdata[7:4];
        end
    end

    // Polarity register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pol_r <= `POL_RST;
        end else if (reg_wr && reg_addr == `ADDR_POLARITY) begin
            pol_r <= reg_wdata[`POL_BIT];
        end
    end

    // Alert mask register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mask_r <= `MASK_RST;
        end else if (reg_wr && reg_addr == `ADDR_ALERT_MASK) begin
            mask_r <= reg_wdata;
        end
    end

    // ==========================================
    // Sticky latches
    assign wr_sticky = reg_wr && (reg_addr == `ADDR_STICKY);
    assign st.good   = good;
    assign st.clr    = wr_sticky ? reg_wdata : '0;

    sticky_bank #(
        .W (`ALERT_W)
    ) u_bank (
        .mclk    (mclk),
        .reset_n (reset_n),
        .st      (st)
    );

    // Interrupt from masked latched events
    assign irq = |(mask_r & ~st.sticky);

    // ==========================================
    // Read data
    always_comb begin
        rdata_nxt = '0;
        case (reg_addr)
            `ADDR_PIN_FUNC:   rdata_nxt = {func1_r, func0_r};
            `ADDR_POLARITY:   rdata_nxt = {7'h00, pol_r};
            `ADDR_ALERT_MASK: rdata_nxt = mask_r;
            `ADDR_STICKY:     rdata_nxt = st.sticky;
            `ADDR_MOMENTARY:  rdata_nxt = good;
            default:          rdata_nxt = '0;
        endcase
    end

    // Read data register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ==========================================
    // Status level for output codes: {drive, level}
    function automatic logic [1:0] status_level(input gpio_status_pkg::func_code_t code,
                                                input gpio_status_pkg::alert_vec_t g,
                                                input logic al,
                                                input logic ir);
        logic [1:0] r;
        r = 2'h0;
        case (code)
            `FN_LOCK0:     r = {1'b1, g[`BIT_LOCK0]};
            `FN_LOCK1:     r = {1'b1, g[`BIT_LOCK1]};
            `FN_LOCK_BOTH: r = {1'b1, g[`BIT_LOCK0] & g[`BIT_LOCK1]};
            `FN_ALARM:     r = {1'b1, al};
            `FN_HOLD:      r = {1'b1, ~g[`BIT_HOLD]};
            `FN_IRQ:       r = {1'b1, ir};
            default:       r = 2'h0;
        endcase
        return r;
    endfunction : status_level

    assign lvl0 = status_level(func0_r, good, alarm, irq);
    assign lvl1 = status_level(func1_r, good, alarm, irq);

    // ==========================================
    // Pin drive selection; reserved and input codes leave the pin undriven
    always_comb begin
        out_nxt = 2'h0;
        oe_nxt  = 2'h0;
        if (func0_r == `FN_SEL_OUT) begin
            oe_nxt  = 2'h3;
            out_nxt = sel_s_r;
        end else begin
            oe_nxt[0]  = lvl0[1];
            out_nxt[0] = lvl0[0];
            if (func0_r != `FN_IN_SELECT) begin
                oe_nxt[1]  = lvl1[1];
                out_nxt[1] = lvl1[0];
            end
        end
        out_nxt = (out_nxt ^ {2{pol_r}}) & oe_nxt;
    end

    // Pin output registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= out_nxt;
            pin_oe  <= oe_nxt;
        end
    end

    // ==========================================
    // Pin input functions
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            force_holdover <= 1'b0;
            force_vc_half  <= 1'b0;
            ext_sel_valid  <= 1'b0;
            ext_sel        <= '0;
        end else begin
            force_holdover <= (func0_r == `FN_FORCE_HOLD && pin_s_r[0])
                            | (func1_r == `FN_FORCE_HOLD && pin_s_r[1]
                               && func0_r != `FN_IN_SELECT);
            force_vc_half  <= (func0_r == `FN_FORCE_VC && pin_s_r[0])
                            | (func1_r == `FN_FORCE_VC && pin_s_r[1]
                               && func0_r != `FN_IN_SELECT);
            ext_sel_valid  <= (func0_r == `FN_IN_SELECT);
            ext_sel        <= pin_s_r;
        end
    end

    // ==========================================
    // Checks
    reset_defaults_a: assert property (@(posedge mclk)
        $rose(reset_n) |-> (func0_r == `FUNC0_RST && func1_r == `FUNC1_RST
                            && pol_r == 1'b0 && mask_r == '0))
        else $error("reset defaults wrong");

    lock0_pin_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (func0_r == `FN_LOCK0) |=>
            (pin_oe[0] && pin_out[0] == ($past(good[`BIT_LOCK0]) ^ $past(pol_r))))
        else $error("lock pin level wrong");

    alarm_pin_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (func1_r == `FN_ALARM && func0_r != `FN_SEL_OUT && func0_r != `FN_IN_SELECT)
            |=> (pin_oe[1] && pin_out[1] == ($past(alarm) ^ $past(pol_r))))
        else $error("alarm pin level wrong");

    irq_raise_a: assert property (@(posedge mclk) disable iff (!reset_n)
        ((mask_r & ~good) != '0) ##1 $stable(mask_r) |-> irq)
        else $error("masked event gave no interrupt");

    mask_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mask_r == '0) |-> !irq)
        else $error("interrupt while all masked");

    force_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (func0_r == `FN_FORCE_HOLD && pin_s_r[0]) |=> (force_holdover && !pin_oe[0]))
        else $error("force holdover input ignored");

    sel_out_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (func0_r == `FN_SEL_OUT) |=>
            (pin_oe == 2'h3 && pin_out == ($past(sel_s_r) ^ {2{$past(pol_r)}})))
        else $error("selected input pins wrong");

    reserved_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (func0_r == `FN_IN_SELECT) |=> (pin_oe == 2'h0 && ext_sel_valid))
        else $error("input select pins driven");

    momentary_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_rd && reg_addr == `ADDR_MOMENTARY) |=> (reg_rdata == $past(good)))
        else $error("momentary readback wrong");

    sticky_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (!good[`CLK_HI]) ##1 (reg_rd && reg_addr == `ADDR_STICKY && !wr_sticky)
            ##1 1'b1 |-> !reg_rdata[`CLK_HI])
        else $error("sticky loss not reported");

endmodule : gpio_status_top

//--- pkg/gpio_status_defs.svh
`ifndef GPIO_STATUS_DEFS_SVH
`define GPIO_STATUS_DEFS_SVH

// ==========================================
// Register offsets
`define ADDR_PIN_FUNC    8'h88
`define ADDR_POLARITY    8'h89
`define ADDR_ALERT_MASK  8'h8c
`define ADDR_STICKY      8'h90
`define ADDR_MOMENTARY   8'h94

// ==========================================
// Reset values
`define FUNC0_RST        4'hb
`define FUNC1_RST        4'ha
`define POL_RST          1'h0
`define MASK_RST         8'h00
`define STICKY_RST       8'hff

// ==========================================
// Field layout
`define ALERT_W          8
`define POL_BIT          0
`define BIT_LOCK0        3
`define BIT_LOCK1        2
`define BIT_HOLD         1
`define BIT_REF          0
`define CLK_HI           7
`define CLK_LO           4
`define HOLD_INV         8'h02

// ==========================================
// Pin function codes
`define FN_FORCE_HOLD    4'h1
`define FN_FORCE_VC      4'h2
`define FN_IN_SELECT     4'h7
`define FN_LOCK0         4'h8
`define FN_LOCK1         4'h9
`define FN_LOCK_BOTH     4'ha
`define FN_ALARM         4'hb
`define FN_HOLD          4'hc
`define FN_IRQ           4'hd
`define FN_SEL_OUT       4'hf

`endif

//--- pkg/gpio_status_pkg.sv
// ==========================================
// Shared types
package gpio_status_pkg;
    typedef logic [3:0] func_code_t;
    typedef logic [7:0] alert_vec_t;
    typedef logic [7:0] reg_byte_t;
endpackage : gpio_status_pkg

//--- pkg/status_if.sv
`timescale 1ns/100ps
// ==========================================
// Sticky bank carrier
interface status_if;
    gpio_status_pkg::alert_vec_t good;
    gpio_status_pkg::alert_vec_t clr;
    gpio_status_pkg::alert_vec_t sticky;
    modport bank  (input good, input clr, output sticky);
    modport owner (output good, output clr, input sticky);
endinterface : status_if

//--- hdl/sticky_bank.sv
`timescale 1ns/100ps
`include "gpio_status_defs.svh"

module sticky_bank #(
    parameter int W = `ALERT_W
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Status carrier
    status_if.bank    st
);

    // ==========================================
    // Latches: clear on write 1, any bad level wins
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st.sticky <= `STICKY_RST;
        end else begin
            st.sticky <= (st.sticky | st.clr) & st.good;
        end
    end

    // ==========================================
    // Checks
    event_wins_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (st.clr != '0) |=> ((st.sticky & ~$past(st.good)) == '0))
        else $error("event lost during clear");

    clear_sets_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (st.good == '1) |=> (st.sticky == ($past(st.sticky) | $past(st.clr))))
        else $error("sticky clear wrong");

endmodule : sticky_bank

//--- verification/pin_board_model.sv
`timescale 1ns/100ps
// ==========================================
// Board logic on the two status pins
module pin_board_model (
    // Device side
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    // Board drive
    input  wire logic [1:0] drv_en,
    input  wire logic [1:0] drv_val,
    // Resolved pin levels
    output logic      [1:0] pin_in
);
    // Device drive wins, then board drive, else pull-up
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (drv_en[i])
                pin_in[i] = drv_val[i];
            else
                pin_in[i] = 1'b1;
        end
    end
endmodule : pin_board_model

//--- verification/testbench.sv
`timescale 1ns/100ps
`include "gpio_status_defs.svh"
module testbench;
    // ==========================================
    // Stimulus and observation
    logic       mclk, reset_n, reg_wr, reg_rd, loop0_locked, loop1_locked;
    logic       in_holdover, ref_present, force_holdover, force_vc_half;
    logic       ext_sel_valid, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] clk_active;
    logic [1:0] selected_input, pin_in, pin_out, pin_oe, ext_sel, drv_en, drv_val;
    int         fail_count = 0;
    int         samples_checked = 0;

    gpio_status_top DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .clk_active(clk_active), .loop0_locked(loop0_locked), .loop1_locked(loop1_locked),
        .in_holdover(in_holdover), .ref_present(ref_present),
        .selected_input(selected_input), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .force_holdover(force_holdover), .force_vc_half(force_vc_half),
        .ext_sel_valid(ext_sel_valid), .ext_sel(ext_sel), .irq(irq));

    pin_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .drv_en(drv_en),
        .drv_val(drv_val), .pin_in(pin_in));

    // Clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ==========================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        reg_rd   = 1'b0;
        @(negedge mclk);
        chk(reg_rdata, e);
    endtask : rd_chk

    task automatic set_mon(input logic [3:0] c, input logic l0, input logic l1,
                           input logic ho, input logic rf);
        @(negedge mclk);
        clk_active   = c;
        loop0_locked = l0;
        loop1_locked = l1;
        in_holdover  = ho;
        ref_present  = rf;
        repeat (5) @(negedge mclk);
    endtask : set_mon

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // ==========================================
    // Scenarios
    task automatic t_reset;
        rd_chk(`ADDR_PIN_FUNC, 8'hab);
        rd_chk(`ADDR_POLARITY, 8'h00);
        rd_chk(`ADDR_ALERT_MASK, 8'h00);
        rd_chk(`ADDR_STICKY, 8'hff);
        wr(8'h8d, 8'hff);
        rd_chk(8'h8d, 8'h00);
        wr(`ADDR_POLARITY, 8'hff);
        rd_chk(`ADDR_POLARITY, 8'h01);
        wr(`ADDR_POLARITY, 8'h00);
    endtask : t_reset

    task automatic t_sticky;
        set_mon(4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        rd_chk(`ADDR_MOMENTARY, 8'h00);
        rd_chk(`ADDR_STICKY, 8'h00);
        chk({7'h0, irq}, 8'h00);
        set_mon(4'hf, 1'b1, 1'b1, 1'b0, 1'b1);
        rd_chk(`ADDR_MOMENTARY, 8'hff);
        rd_chk(`ADDR_STICKY, 8'h00);
        wr(`ADDR_ALERT_MASK, 8'hff);
        chk({7'h0, irq}, 8'h01);
        wr(`ADDR_PIN_FUNC, 8'hdd);
        repeat (4) @(negedge mclk);
        chk({6'h0, pin_oe, pin_out}, 8'h0f);
        wr(`ADDR_STICKY, 8'h00);
        rd_chk(`ADDR_STICKY, 8'h00);
        wr(`ADDR_STICKY, 8'h80);
        rd_chk(`ADDR_STICKY, 8'h80);
        set_mon(4'hd, 1'b1, 1'b1, 1'b0, 1'b1);
        wr(`ADDR_STICKY, 8'h40);
        rd_chk(`ADDR_STICKY, 8'h80);
        set_mon(4'hf, 1'b1, 1'b1, 1'b0, 1'b1);
        wr(`ADDR_STICKY, 8'h7f);
        rd_chk(`ADDR_STICKY, 8'hff);
        chk({7'h0, irq}, 8'h00);
        wr(`ADDR_ALERT_MASK, 8'h01);
        set_mon(4'hf, 1'b1, 1'b1, 1'b0, 1'b0);
        chk({7'h0, irq}, 8'h01);
        set_mon(4'hf, 1'b1, 1'b1, 1'b0, 1'b1);
        wr(`ADDR_ALERT_MASK, 8'h00);
        wr(`ADDR_STICKY, 8'hff);
    endtask : t_sticky

    task automatic t_pins;
        logic [3:0] codes [6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
        logic       expv  [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        set_mon(4'he, 1'b1, 1'b0, 1'b0, 1'b1);
        for (int p = 0; p < 2; p++) begin
            wr(`ADDR_POLARITY, 8'(p));
            for (int i = 0; i < 6; i++) begin
                wr(`ADDR_PIN_FUNC, {codes[i], codes[i]});
                repeat (4) @(negedge mclk);
                chk({6'h0, pin_oe}, 8'h03);
                chk({6'h0, pin_out}, {6'h0, {2{expv[i] ^ p[0]}}});
            end
        end
        wr(`ADDR_POLARITY, 8'h00);
    endtask : t_pins

    task automatic t_inputs;
        wr(`ADDR_PIN_FUNC, 8'h21);
        drv_en  = 2'b11;
        drv_val = 2'b11;
        repeat (5) @(negedge mclk);
        chk({pin_oe, force_holdover, force_vc_half}, 8'h03);
        drv_val = 2'b00;
        repeat (5) @(negedge mclk);
        chk({force_holdover, force_vc_half}, 8'h00);
        drv_val = 2'b10;
        wr(`ADDR_PIN_FUNC, 8'ha7);
        repeat (5) @(negedge mclk);
        chk({pin_oe, ext_sel_valid, ext_sel}, 8'h06);
        drv_en = 2'b00;
        selected_input = 2'b01;
        wr(`ADDR_PIN_FUNC, 8'haf);
        repeat (5) @(negedge mclk);
        chk({pin_oe, pin_out}, 8'h0d);
        wr(`ADDR_POLARITY, 8'h01);
        repeat (4) @(negedge mclk);
        chk({6'h0, pin_out}, 8'h02);
    endtask : t_inputs

    // ==========================================
    // Main sequence
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        clk_active = 4'hf;
        loop0_locked = 1'b1;
        loop1_locked = 1'b1;
        in_holdover = 1'b0;
        ref_present = 1'b1;
        selected_input = 2'b10;
        drv_en = 2'b00;
        drv_val = 2'b00;
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        t_reset();
        t_sticky();
        t_pins();
        t_inputs();
        wrap_up();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end
endmodule : testbench
